// >>> src/status_sel_pkg.sv
// Constants shared by the status output selector: map, fields, timing.
package status_sel_pkg;
    // Word registers, byte addresses on an 8-bit address
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_GROUP = 8'h04;
    localparam logic [7:0] ADDR_STATE = 8'h08;
    localparam logic [7:0] ADDR_FIRST = 8'h0C;
    localparam logic [7:0] ADDR_PSTAT = 8'h10;
    localparam logic [7:0] ADDR_VSTAT = 8'h14;
    localparam logic [7:0] ADDR_NET_IN = 8'h18;
    localparam logic [7:0] ADDR_NET_OUT = 8'h1C;
    // Config windows: physical at 0x40 + 4k, virtual at 0x80 + 4k
    localparam logic [1:0] PHYS_WIN = 2'h1;
    localparam logic [0:0] VIRT_WIN = 1'h1;
    // CTRL fields
    localparam int CTRL_NET_EN_BIT = 0;
    localparam int CTRL_PWR_MAN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    // Per-output config fields
    localparam int CFG_W = 18;
    localparam int CFG_FUNC_LSB = 0;
    localparam int CFG_SRC_LSB = 8;
    localparam int CFG_INV_BIT = 16;
    localparam int CFG_LOGIC_BIT = 17;
    localparam logic [CFG_W-1:0] CFG_RESET = 18'h00000;
    localparam logic [31:0] GROUP_RESET = 32'h00000000;
    // Tracked function codes
    localparam logic [3:0] FN_NONE = 4'h0;
    localparam logic [3:0] FN_TRACK_IN = 4'h1;
    localparam logic [3:0] FN_TRACK_OUT = 4'h2;
    localparam logic [3:0] FN_LOCKOUT = 4'h3;
    localparam logic [3:0] FN_IO_FAULT = 4'h4;
    localparam logic [3:0] FN_SYS_WAIT = 4'h5;
    localparam logic [3:0] FN_OUT_WAIT = 4'h6;
    localparam logic [3:0] FN_MUTE = 4'h7;
    localparam logic [3:0] FN_GROUP = 4'h8;
    localparam logic [3:0] FN_BYPASS = 4'h9;
    localparam logic [3:0] FN_IN_FAULT = 4'hA;
    localparam logic [3:0] FN_CANCEL_OK = 4'hB;
    // Timing
    localparam longint CLK_HZ = 200000000;
    localparam longint VIRT_PERIOD_MS = 100;
    localparam longint NET_PERIOD_MS = 1000;
    localparam longint FLASH_HALF_MS = 250;
    localparam int VIRT_CYC = int'(CLK_HZ * VIRT_PERIOD_MS / 1000);
    localparam int NET_CYC = int'(CLK_HZ * NET_PERIOD_MS / 1000);
    localparam int FLASH_HALF_CYC = int'(CLK_HZ * FLASH_HALF_MS / 1000);
    localparam int N_VIRT = 32;
endpackage : status_sel_pkg

// >>> src/status_output_selector.sv
// Status output selector: physical and virtual status outputs of a safety controller.
`timescale 1ns/1ps

// Operation
// R1 - Each status output has own polarity; default drives high when condition true.
// R2 - Alternate polarity drives exact inverse level for every tracked function.
// R3 - Input tracking follows present run/stop state of selected input.
// R4 - Output tracking follows actual on/off state of selected safety output.
// R5 - Option follows commanded state, going off at once during an OFF-delay.
// R6 - System lockout function active while a controller-wide lockout is present.
// R7 - I/O fault function active while a lockout confined to one I/O exists.
// R8 - System-waiting-for-reset set by listed faults or manual power-up reset.
// R9 - Config exit, enable exit, group re-enable resets give no waiting indication.
// R10 - Output-waiting function active while output held off only by manual reset.
// R11 - Mute status steady on when muted/bypassed, off otherwise, flashing for override.
// R12 - Group tracking marks the input that turned off first, others inactive.
// R13 - First-off capture re-armed only by system reset with whole group on.
// R14 - Bypass status only while truly bypassed, after input seen inactive once.
// R15 - No bypass at power-up; input must be seen open first.
// R16 - Input-fault function active whenever any fault is on selected input.
// R17 - Cancel-OFF-delay function active exactly while cancel input may be used.
// R18 - Up to 32 virtual outputs, same functions, only with network enabled.
// R19 - Virtual data fresh within 100 ms, other network tables within 1 s.
// R20 - Network states taken only from debounced and tested logical signals.
// R21 - Override flash comes from free-running clock divider with parameter period.
module status_output_selector #(
    parameter int N_STAT = 10,
    parameter int N_IN = 22,
    parameter int N_OUT = 6,
    parameter int VIRT_CYCLES = status_sel_pkg::VIRT_CYC,
    parameter int NET_CYCLES = status_sel_pkg::NET_CYC,
    parameter int FLASH_HALF_CYCLES = status_sel_pkg::FLASH_HALF_CYC
) (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire logic [N_IN-1:0] in_run_in,
    input wire logic [N_IN-1:0] in_fault_in,
    input wire logic [N_IN-1:0] mute_active_in,
    input wire logic [N_IN-1:0] bypass_active_in,
    input wire logic [N_IN-1:0] override_ready_in,
    input wire logic [N_OUT-1:0] out_phys_in,
    input wire logic [N_OUT-1:0] out_cmd_in,
    input wire logic [N_OUT-1:0] out_ready_in,
    input wire logic [N_OUT-1:0] cancel_ok_in,
    input wire logic sys_lockout_in,
    input wire logic io_fault_in,
    input wire logic sys_fault_in,
    input wire logic external_device_monitor_fault_in,
    input wire logic actuator_valve_monitor_fault_in,
    input wire logic out_fault_in,
    input wire logic mute_lamp_fault_in,
    input wire logic two_hand_control_fault_in,
    input wire logic sys_reset_in,
    output logic [N_STAT-1:0] status_out,
    output logic [status_sel_pkg::N_VIRT-1:0] vstat_out,
    output logic [31:0] net_in_out,
    output logic [31:0] net_out_out
);
    import status_sel_pkg::*;

    localparam int NE = N_STAT + N_VIRT;

    // Register state
    logic [CFG_W-1:0] cfg_q [NE];
    logic [1:0] ctrl_q;
    logic [31:0] group_q;
    logic [31:0] rdata_q;
    logic wait_q;
    logic pwr_done_q;
    logic armed_q;
    logic [31:0] first_q;
    logic [31:0] seen_open_q;
    logic [N_STAT-1:0] stat_q;
    logic [N_VIRT-1:0] vstat_q;
    logic [31:0] net_in_q;
    logic [31:0] net_out_q;
    logic [31:0] vcnt_q;
    logic [31:0] ncnt_q;
    logic [31:0] fcnt_q;
    logic flash_q;

    // Sources zero-extended so any 5-bit source index is safe
    wire [31:0] run_w = 32'(in_run_in);
    wire [31:0] ifault_w = 32'(in_fault_in);
    wire [31:0] mute_w = 32'(mute_active_in);
    wire [31:0] byp_w = 32'(bypass_active_in);
    wire [31:0] ovr_w = 32'(override_ready_in);
    wire [31:0] ophys_w = 32'(out_phys_in);
    wire [31:0] ocmd_w = 32'(out_cmd_in);
    wire [31:0] ordy_w = 32'(out_ready_in);
    wire [31:0] cancel_w = 32'(cancel_ok_in);
    wire [31:0] inmask_w = 32'((64'h1 << N_IN) - 64'h1);

    wire net_en_w = ctrl_q[CTRL_NET_EN_BIT];
    wire pwr_man_w = ctrl_q[CTRL_PWR_MAN_BIT];

    // Bus decode
    wire phys_sel_w = addr_in[7:6] == PHYS_WIN;
    wire virt_sel_w = addr_in[7:7] == VIRT_WIN;
    wire [4:0] phys_idx_w = {1'b0, addr_in[5:2]};
    wire [4:0] virt_idx_w = addr_in[6:2];
    wire phys_ok_w = phys_sel_w && (32'(phys_idx_w) < N_STAT);
    wire [5:0] cfg_idx_w = virt_sel_w ? 6'(N_STAT + 32'(virt_idx_w)) : 6'(phys_idx_w);
    wire cfg_hit_w = virt_sel_w || phys_ok_w;
    wire wr_ctrl_w = wr_in && addr_in == ADDR_CTRL;
    wire wr_group_w = wr_in && addr_in == ADDR_GROUP;

    // Bypass only counts once the input has been seen open
    wire [31:0] byp_ind_w = byp_w & seen_open_q;

    // Group first-off capture
    wire [31:0] grp_off_w = group_q & ~run_w & inmask_w;
    wire grp_all_on_w = grp_off_w == 32'h00000000;
    wire [31:0] grp_first_w = grp_off_w & (~grp_off_w + 32'h00000001);
    wire rearm_w = sys_reset_in && grp_all_on_w;

    // Waiting-for-reset causes; mode-change resets are not causes
    // Power-up manual cause pends until the first system reset ends it
    wire pwr_set_w = !pwr_done_q && pwr_man_w && !sys_reset_in;
    wire all_off_w = ophys_w == 32'h00000000;
    wire wait_set_w = (sys_fault_in && all_off_w) || external_device_monitor_fault_in
        || actuator_valve_monitor_fault_in || out_fault_in || mute_lamp_fault_in
        || two_hand_control_fault_in || pwr_set_w;

    // Per-entry tracked condition and driven level
    logic [NE-1:0] cond_w;
    logic [NE-1:0] level_w;
    logic [31:0] cfg_rd_w [NE];

    genvar k;
    generate
        for (k = 0; k < NE; k++) begin : g_ent
            wire [3:0] fn = cfg_q[k][CFG_FUNC_LSB +: 4];
            wire [4:0] src = cfg_q[k][CFG_SRC_LSB +: 5];
            wire inv = cfg_q[k][CFG_INV_BIT];
            wire use_cmd = cfg_q[k][CFG_LOGIC_BIT];
            wire mute_c = (mute_w[src] || byp_ind_w[src]) ? 1'b1
                : (ovr_w[src] ? flash_q : 1'b0);
            always_comb begin
                case (fn)
                    // R3 input tracking
                    FN_TRACK_IN: cond_w[k] = run_w[src];
                    // R4 R5 actual or commanded state
                    FN_TRACK_OUT: cond_w[k] = use_cmd ? ocmd_w[src] : ophys_w[src];
                    // R6 controller lockout
                    FN_LOCKOUT: cond_w[k] = sys_lockout_in;
                    // R7 confined fault
                    FN_IO_FAULT: cond_w[k] = io_fault_in;
                    FN_SYS_WAIT: cond_w[k] = wait_q;
                    // R10 pending manual reset
                    FN_OUT_WAIT: cond_w[k] = ordy_w[src];
                    // R11 steady or flashing
                    FN_MUTE: cond_w[k] = mute_c;
                    // R12 first-off marker
                    FN_GROUP: cond_w[k] = first_q[src];
                    // R14 truly bypassed
                    FN_BYPASS: cond_w[k] = byp_ind_w[src];
                    // R16 any input fault
                    FN_IN_FAULT: cond_w[k] = ifault_w[src];
                    // R17 cancel permission
                    FN_CANCEL_OK: cond_w[k] = cancel_w[src];
                    default: cond_w[k] = 1'b0;
                endcase
            end
            // R1 R2 polarity select
            assign level_w[k] = cond_w[k] ^ inv;
            assign cfg_rd_w[k] = 32'(cfg_q[k]);

            always_ff @(posedge clk_sys_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    cfg_q[k] <= CFG_RESET;
                end else if (wr_in && cfg_hit_w && 32'(cfg_idx_w) == k) begin
                    cfg_q[k] <= wdata_in[CFG_W-1:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            stat_q <= '0;
        end else begin
            stat_q <= level_w[N_STAT-1:0];
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl_q <= CTRL_RESET;
            group_q <= GROUP_RESET;
        end else begin
            if (wr_ctrl_w) begin
                ctrl_q <= wdata_in[1:0];
            end
            if (wr_group_w) begin
                group_q <= wdata_in;
            end
        end
    end

    // R8 R9 sticky wait flag, set beats the clearing reset
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wait_q <= 1'b0;
            pwr_done_q <= 1'b0;
        end else begin
            wait_q <= wait_set_w || (wait_q && !sys_reset_in);
            pwr_done_q <= pwr_done_q || sys_reset_in;
        end
    end

    // R12 R13 capture once, re-arm on reset with group all on
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            armed_q <= 1'b0;
            first_q <= 32'h00000000;
        end else if (wr_group_w) begin
            armed_q <= 1'b0;
            first_q <= 32'h00000000;
        end else if (armed_q && !grp_all_on_w) begin
            armed_q <= 1'b0;
            first_q <= grp_first_w;
        end else if (!armed_q && rearm_w) begin
            armed_q <= 1'b1;
            first_q <= 32'h00000000;
        end
    end

    // R15 power-up clears, bypass waits for an open input
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            seen_open_q <= 32'h00000000;
        end else begin
            seen_open_q <= seen_open_q | (~run_w & inmask_w);
        end
    end

    // R21 free-running flash divider
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            fcnt_q <= 32'h00000000;
            flash_q <= 1'b0;
        end else if (fcnt_q >= 32'(FLASH_HALF_CYCLES - 1)) begin
            fcnt_q <= 32'h00000000;
            flash_q <= !flash_q;
        end else begin
            fcnt_q <= fcnt_q + 32'h00000001;
        end
    end

    // R18 R19 virtual snapshot, refreshed each period, blank when disabled
    wire vtick_w = vcnt_q >= 32'(VIRT_CYCLES - 1);
    wire ntick_w = ncnt_q >= 32'(NET_CYCLES - 1);
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            vcnt_q <= 32'h00000000;
            vstat_q <= '0;
        end else begin
            vcnt_q <= vtick_w ? 32'h00000000 : vcnt_q + 32'h00000001;
            if (!net_en_w) begin
                vstat_q <= '0;
            end else if (vtick_w) begin
                vstat_q <= level_w[NE-1:N_STAT];
            end
        end
    end

    // R19 R20 slower tables from debounced logical states only
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ncnt_q <= 32'h00000000;
            net_in_q <= 32'h00000000;
            net_out_q <= 32'h00000000;
        end else begin
            ncnt_q <= ntick_w ? 32'h00000000 : ncnt_q + 32'h00000001;
            if (!net_en_w) begin
                net_in_q <= 32'h00000000;
                net_out_q <= 32'h00000000;
            end else if (ntick_w) begin
                net_in_q <= run_w;
                net_out_q <= ocmd_w;
            end
        end
    end

    // Read path; unmapped words read zero
    wire [31:0] state_rd_w = {29'h0, armed_q, flash_q, wait_q};
    logic [31:0] rd_mux_w;
    always_comb begin
        rd_mux_w = 32'h00000000;
        if (cfg_hit_w) begin
            rd_mux_w = cfg_rd_w[cfg_idx_w];
        end else begin
            case (addr_in)
                ADDR_CTRL: rd_mux_w = 32'(ctrl_q);
                ADDR_GROUP: rd_mux_w = group_q;
                ADDR_STATE: rd_mux_w = state_rd_w;
                ADDR_FIRST: rd_mux_w = first_q;
                ADDR_PSTAT: rd_mux_w = 32'(stat_q);
                ADDR_VSTAT: rd_mux_w = vstat_q;
                ADDR_NET_IN: rd_mux_w = net_in_q;
                ADDR_NET_OUT: rd_mux_w = net_out_q;
                default: rd_mux_w = 32'h00000000;
            endcase
        end
    end

    // Data only in the cycle after the read strobe
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= rd_in ? rd_mux_w : 32'h00000000;
        end
    end

    assign rdata_out = rdata_q;
    assign status_out = stat_q;
    assign vstat_out = vstat_q;
    assign net_in_out = net_in_q;
    assign net_out_out = net_out_q;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);

    sequence s_edm_fault;
        external_device_monitor_fault_in;
    endsequence
    sequence s_wait_kept;
        wait_q [*2];
    endsequence

    generate
        for (k = 0; k < N_STAT; k++) begin : g_chk
            a_pol_level: assert property ( // R1 R2
                ##1 status_out[k] == ($past(cond_w[k]) ^ $past(cfg_q[k][CFG_INV_BIT])))
                else $error("status level does not match condition and polarity");
        end
    endgenerate

    a_wait_set: assert property ( // R8
        s_edm_fault |=> s_wait_kept or (wait_q ##1 !wait_q))
        else $error("wait flag not set by monitor fault");

    a_wait_hold: assert property ( // R9
        wait_q && !sys_reset_in |=> wait_q)
        else $error("wait flag dropped without system reset");

    a_first_onehot: assert property ( // R12
        $onehot0(first_q))
        else $error("more than one first-off input marked");

    a_group_rearm: assert property ( // R13
        !armed_q && !rearm_w && !wr_group_w |=> !armed_q)
        else $error("group capture re-armed without reset and all inputs on");

    a_bypass_seen: assert property ( // R14 R15
        (byp_ind_w & ~seen_open_q) == 32'h00000000)
        else $error("bypass shown before input seen open");

    a_virt_gate: assert property ( // R18
        !net_en_w |=> vstat_out == '0 && net_in_out == 32'h00000000)
        else $error("virtual outputs presented with network disabled");

    a_virt_fresh: assert property ( // R19
        vcnt_q < 32'(VIRT_CYCLES) && ncnt_q < 32'(NET_CYCLES))
        else $error("network refresh period exceeded");

    a_flash_toggle: assert property ( // R21
        $changed(flash_q) |-> $past(fcnt_q) >= 32'(FLASH_HALF_CYCLES - 1))
        else $error("flash toggled before its half period");

    a_read_once: assert property (
        !rd_in |=> rdata_out == 32'h00000000)
        else $error("read data outside the cycle after the strobe");
endmodule : status_output_selector

// >>> verif/status_lamp_model.sv
// Indicator lamp model that mirrors the status outputs and counts changes of one lamp.
`timescale 1ns/1ps
module status_lamp_model #(
    parameter int N = 10
) (
    input wire logic clk_in,
    input wire logic clr_in,
    input wire logic [3:0] sel_in,
    input wire logic [N-1:0] drive_in,
    output logic [N-1:0] lamp_out,
    output int flips_out
);
    always @(posedge clk_in) begin
        lamp_out <= drive_in;
        if (clr_in) begin
            flips_out <= 0;
        end else if (lamp_out[sel_in] !== drive_in[sel_in]) begin
            flips_out <= flips_out + 1;
        end
    end
endmodule : status_lamp_model

// >>> verif/status_output_selector_tb_top.sv
// Self-checking bench for the status output selector.
`timescale 1ns/1ps
module status_output_selector_tb_top;
    import status_sel_pkg::*;
    logic clk_sys_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [31:0] rdata_out;
    logic [21:0] in_run_in = '1;
    logic [21:0] in_fault_in = '0;
    logic [21:0] mute_active_in = '0;
    logic [21:0] bypass_active_in = '0;
    logic [21:0] override_ready_in = '0;
    logic [5:0] out_phys_in = '0;
    logic [5:0] out_cmd_in = '0;
    logic [5:0] out_ready_in = '0;
    logic [5:0] cancel_ok_in = '0;
    logic sys_lockout_in = 1'b0;
    logic io_fault_in = 1'b0;
    logic sys_fault_in = 1'b0;
    logic [4:0] evt = '0;
    logic sys_reset_in = 1'b0;
    logic [9:0] status_out;
    logic [31:0] vstat_out;
    logic [31:0] net_in_out;
    logic [31:0] net_out_out;
    logic clr = 1'b0;
    int flips;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    logic [3:0] fns [8] = '{FN_TRACK_IN, FN_TRACK_OUT, FN_LOCKOUT, FN_IO_FAULT,
        FN_OUT_WAIT, FN_IN_FAULT, FN_CANCEL_OK, FN_MUTE};

    always #2.5 clk_sys_in = ~clk_sys_in;

    status_output_selector #(.VIRT_CYCLES(8), .NET_CYCLES(16),
        .FLASH_HALF_CYCLES(4)) status_output_selector_i (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .in_run_in(in_run_in), .in_fault_in(in_fault_in),
        .mute_active_in(mute_active_in), .bypass_active_in(bypass_active_in),
        .override_ready_in(override_ready_in), .out_phys_in(out_phys_in),
        .out_cmd_in(out_cmd_in), .out_ready_in(out_ready_in), .cancel_ok_in(cancel_ok_in),
        .sys_lockout_in(sys_lockout_in), .io_fault_in(io_fault_in),
        .sys_fault_in(sys_fault_in), .external_device_monitor_fault_in(evt[0]),
        .actuator_valve_monitor_fault_in(evt[1]), .out_fault_in(evt[2]),
        .mute_lamp_fault_in(evt[3]), .two_hand_control_fault_in(evt[4]),
        .sys_reset_in(sys_reset_in), .status_out(status_out), .vstat_out(vstat_out),
        .net_in_out(net_in_out), .net_out_out(net_out_out));

    status_lamp_model status_lamp_model_i (.clk_in(clk_sys_in), .clr_in(clr),
        .sel_in(4'h0), .drive_in(status_out), .lamp_out(), .flips_out(flips));

    task automatic close_out;
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    // Ceiling well above the few hundred cycles the tests need
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : cmp

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        // Data stand only until the next edge
        @(negedge clk_sys_in);
        cmp(rdata_out, e);
        @(posedge clk_sys_in);
    endtask : rd

    task automatic cfg(input int k, input logic [3:0] fn, input int src, input bit inv,
            input bit lg);
        wr(8'(8'h40 + 4 * k), (32'(lg) << CFG_LOGIC_BIT) | (32'(inv) << CFG_INV_BIT)
            | (32'(src) << CFG_SRC_LSB) | 32'(fn));
    endtask : cfg

    task automatic stat(input int b, input logic e);
        repeat (2) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        cmp(32'(status_out[b]), 32'(e));
        @(posedge clk_sys_in);
    endtask : stat

    task automatic cause(input logic [3:0] fn, input logic v);
        @(posedge clk_sys_in);
        case (fn)
            FN_TRACK_IN: in_run_in[3] <= v;
            FN_TRACK_OUT: out_phys_in[3] <= v;
            FN_LOCKOUT: sys_lockout_in <= v;
            FN_IO_FAULT: io_fault_in <= v;
            FN_OUT_WAIT: out_ready_in[3] <= v;
            FN_IN_FAULT: in_fault_in[3] <= v;
            FN_CANCEL_OK: cancel_ok_in[3] <= v;
            default: mute_active_in[3] <= v;
        endcase
    endtask : cause

    task automatic pulse_reset;
        @(posedge clk_sys_in);
        sys_reset_in <= 1'b1;
        @(posedge clk_sys_in);
        sys_reset_in <= 1'b0;
    endtask : pulse_reset

    initial begin
        repeat (20) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        rd(ADDR_CTRL, 32'h0);
        rd(ADDR_PSTAT, 32'h0);
        rd(8'h3C, 32'h0);
        wr(8'h68, 32'h1);
        rd(8'h68, 32'h0);
        // Manual power-up pends until the first system reset
        cfg(9, FN_SYS_WAIT, 0, 0, 0);
        wr(ADDR_CTRL, 32'h2);
        stat(9, 1'b1);
        $display("test reset done");
        // Bypass before the input was ever open must stay dark
        cfg(0, FN_BYPASS, 4, 0, 0);
        rd(8'h40, 32'h00000409);
        bypass_active_in[4] <= 1'b1;
        stat(0, 1'b0);
        in_run_in[4] <= 1'b0;
        @(posedge clk_sys_in);
        in_run_in[4] <= 1'b1;
        stat(0, 1'b1);
        cfg(0, FN_MUTE, 4, 0, 0);
        stat(0, 1'b1);
        bypass_active_in[4] <= 1'b0;
        stat(0, 1'b0);
        $display("test bypass done");
        for (int i = 0; i < 8; i++) begin
            for (int inv = 0; inv < 2; inv++) begin
                cfg(1, fns[i], 3, inv[0], 0);
                cause(fns[i], 1'b1);
                stat(1, ~inv[0]);
                cause(fns[i], 1'b0);
                stat(1, inv[0]);
            end
        end
        cfg(1, FN_TRACK_OUT, 3, 0, 1);
        out_phys_in[3] <= 1'b1;
        stat(1, 1'b0);
        out_cmd_in[3] <= 1'b1;
        stat(1, 1'b1);
        $display("test functions done");
        cfg(0, FN_MUTE, 6, 0, 0);
        override_ready_in[6] <= 1'b1;
        clr <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        clr <= 1'b0;
        repeat (40) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        cmp(32'(flips inside {[9:11]}), 32'h1);
        @(posedge clk_sys_in);
        override_ready_in[6] <= 1'b0;
        $display("test flash done");
        cfg(9, FN_SYS_WAIT, 0, 0, 0);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_sys_in);
            out_phys_in <= '0;
            if (i < 5) evt[i] <= 1'b1;
            else sys_fault_in <= 1'b1;
            @(posedge clk_sys_in);
            evt <= '0;
            sys_fault_in <= 1'b0;
            stat(9, 1'b1);
            pulse_reset();
            stat(9, 1'b0);
        end
        out_phys_in[0] <= 1'b1;
        sys_fault_in <= 1'b1;
        stat(9, 1'b0);
        sys_fault_in <= 1'b0;
        $display("test wait done");
        cfg(1, FN_GROUP, 9, 0, 0);
        cfg(2, FN_GROUP, 8, 0, 0);
        wr(ADDR_GROUP, 32'h00000700);
        rd(ADDR_GROUP, 32'h00000700);
        stat(9, 1'b0);
        pulse_reset();
        in_run_in[9] <= 1'b0;
        @(posedge clk_sys_in);
        in_run_in[8] <= 1'b0;
        stat(1, 1'b1);
        stat(2, 1'b0);
        rd(ADDR_FIRST, 32'h00000200);
        pulse_reset();
        rd(ADDR_FIRST, 32'h00000200);
        in_run_in[9:8] <= 2'b11;
        pulse_reset();
        rd(ADDR_FIRST, 32'h0);
        $display("test group done");
        wr(8'h80, 32'(FN_TRACK_IN) | (32'd3 << CFG_SRC_LSB));
        in_run_in[3] <= 1'b1;
        repeat (20) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        cmp(vstat_out, 32'h0);
        wr(ADDR_CTRL, 32'h1);
        repeat (20) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        cmp(32'(vstat_out[0]), 32'h1);
        cmp(net_in_out, 32'(in_run_in));
        cmp(net_out_out, 32'(out_cmd_in));
        rd(ADDR_VSTAT, 32'h00000001);
        in_run_in[3] <= 1'b0;
        repeat (12) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        cmp(32'(vstat_out[0]), 32'h0);
        $display("test network done");
        close_out();
    end
endmodule : status_output_selector_tb_top
